// File: mic_detect_pkg.sv
// Constants shared by the microphone bias and current detect logic.
// Assumes a 125 MHz system clock and a decoded register write/read port.
package mic_detect_pkg;

    // Register offsets
    localparam logic [7:0] PWR_MGMT_ONE_ADDR = 8'h19;
    localparam logic [7:0] BIAS_DETECT_ADDR = 8'h30;

    // Field positions
    localparam int BIAS_ENABLE_BIT = 1;
    localparam int BIAS_LEVEL_BIT = 0;
    localparam int DETECT_ENABLE_BIT = 9;
    localparam int ACC_THR_LSB = 12;
    localparam int ACC_THR_MSB = 14;
    localparam int SHORT_THR_LSB = 10;
    localparam int SHORT_THR_MSB = 11;
    localparam int ACC_STATUS_BIT = 7;
    localparam int SHORT_STATUS_BIT = 6;

    // Reset values
    localparam logic BIAS_ENABLE_RST = 1'h0;
    localparam logic BIAS_LEVEL_RST = 1'h1;
    localparam logic DETECT_ENABLE_RST = 1'h0;
    localparam logic [2:0] ACC_THR_RST = 3'h0;
    localparam logic [1:0] SHORT_THR_RST = 2'h0;
    localparam logic STATUS_RST = 1'h0;

    // Filtering: consecutive agreeing measurements before a change is taken
    localparam int ACC_FILTER_COUNT = 1;
    localparam int SHORT_FILTER_COUNT = 10;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MEAS_PERIOD_NS = 1000;
    localparam int MEAS_CYCLES = MEAS_PERIOD_NS / CLK_PERIOD_NS;

    // Gain amplifier source code per side
    typedef enum logic [1:0] {
        SRC_PIN_ONE = 2'h0,
        SRC_PIN_TWO = 2'h1,
        SRC_PIN_THREE = 2'h2,
        SRC_PIN_FOUR = 2'h3
    } pga_src_t;

endpackage : mic_detect_pkg

// File: det_if.sv
// Handshake between the detect controller and one measurement filter.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ns
interface det_if;
    logic tick;
    logic run;
    logic sample;
    logic level;
    logic changed;
    modport filter (input tick, input run, input sample, output level, output changed);
    modport ctrl (output tick, output run, output sample, input level, input changed);
endinterface : det_if

// File: pin_sync3.sv
// Three-stage synchroniser for an asynchronous comparator level.
// Assumes the input may change at any time relative to sys_clk.
`timescale 1ns/1ns
module pin_sync3 (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic async_in,
    output logic level_ff
);
    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1_ff <= 1'h0;
            stage2_ff <= 1'h0;
            stage3_ff <= 1'h0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // A change is taken only when the last two stages agree
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            level_ff <= 1'h0;
        end else if (stage2_ff == stage3_ff) begin
            level_ff <= stage3_ff;
        end
    end
endmodule : pin_sync3

// File: det_filter.sv
// Consecutive-measurement filter for one current comparison.
// Assumes tick is a one-cycle measurement strobe and run the detect enable.
`timescale 1ns/1ns
module det_filter #(
    parameter int COUNT = 10
) (
    input wire logic sys_clk,
    input wire logic reset,
    det_if.filter port
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    logic [CW-1:0] cnt_ff;

    always_ff @(posedge sys_clk) begin
        if (reset || !port.run) begin
            cnt_ff <= '0;
            port.level <= 1'h0;
            port.changed <= 1'h0;
        end else if (port.tick && port.sample != port.level) begin
            if (cnt_ff == LAST) begin
                cnt_ff <= '0;
                port.level <= port.sample;
                port.changed <= 1'h1;
            end else begin
                cnt_ff <= cnt_ff + CW'(1);
                port.changed <= 1'h0;
            end
        end else begin
            if (port.tick) begin
                cnt_ff <= '0;
            end
            port.changed <= 1'h0;
        end
    end

    a_filter_count: assert property (@(posedge sys_clk) disable iff (reset)
        (port.run && $past(port.run) && $changed(port.level))
            |-> $past(cnt_ff) == LAST && $past(port.tick))
        else $error("filter level moved before full count");

    a_filter_hold: assert property (@(posedge sys_clk) disable iff (reset)
        (port.run && !port.tick) |=> (!$past(port.run) || $stable(cnt_ff)))
        else $error("filter advanced without a measurement strobe");
endmodule : det_filter

// File: mic_bias_detect_top.sv
// Microphone bias control, input routing and bias current detection.
// Assumes a decoded register port from the serial control interface,
// comparator levels arriving asynchronously from the analogue block,
// and clock_criteria_ok generated on sys_clk by the clocking logic.
//
// Behaviour
// - One source per side into gain amplifier
// - Pin two/three source adds pin one
// - Pins two, three may bypass to boost
// - Pin four may feed output mixers
// - Bias enable bit drives bias output
// - Bias level bit selects supply fraction
// - One enable gates both current detections
// - Three-bit accessory threshold field, reset zero
// - Two-bit short threshold field, reset zero
// - Accessory status follows live comparison
// - Short status follows live comparison
// - Threshold crossings raise event pulses
// - Detection results available on pin outputs
// - Short change needs ten consecutive measurements
// - Polarity picks accessory event edge
// - Events held until clock criteria return
`timescale 1ns/1ns
module mic_bias_detect_top #(
    parameter int MEAS_CYCLES = mic_detect_pkg::MEAS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    input wire logic acc_compare_in,
    input wire logic short_compare_in,
    input wire logic clock_criteria_ok,
    input wire logic accessory_edge_polarity,
    input wire logic short_edge_polarity,
    input wire logic [1:0][1:0] pga_src_sel,
    input wire logic [1:0] pga_enable,
    input wire logic [1:0] boost_pin_two_sel,
    input wire logic [1:0] boost_pin_three_sel,
    input wire logic [1:0] mixer_pin_four_sel,
    output logic bias_output_enable_ff,
    output logic bias_voltage_select_ff,
    output logic current_detect_enable_ff,
    output logic [2:0] accessory_threshold_sel_ff,
    output logic [1:0] short_threshold_sel_ff,
    output logic accessory_over_flag_ff,
    output logic short_over_flag_ff,
    output logic accessory_gpio_ff,
    output logic short_gpio_ff,
    output logic accessory_event_ff,
    output logic short_event_ff,
    output logic [1:0][3:0] pga_pin_connect_ff,
    output logic [1:0][1:0] boost_connect_ff,
    output logic [1:0] mixer_four_connect_ff
);
    localparam int MW = $clog2(MEAS_CYCLES);
    localparam logic [MW-1:0] MEAS_LAST = MW'(MEAS_CYCLES - 1);

    logic acc_sync;
    logic short_sync;
    logic [MW-1:0] meas_cnt_ff;
    logic meas_tick_ff;
    logic wr_pwr;
    logic wr_det;
    logic [15:0] nxt_rdata;

    det_if acc_if ();
    det_if short_if ();

    assign wr_pwr = reg_wr && reg_addr == mic_detect_pkg::PWR_MGMT_ONE_ADDR;
    assign wr_det = reg_wr && reg_addr == mic_detect_pkg::BIAS_DETECT_ADDR;

    // Analogue comparators are not related to sys_clk
    pin_sync3 acc_sync_u (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(acc_compare_in),
        .level_ff(acc_sync)
    );

    pin_sync3 short_sync_u (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(short_compare_in),
        .level_ff(short_sync)
    );

    // Control register fields
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bias_output_enable_ff <= mic_detect_pkg::BIAS_ENABLE_RST;
        end else if (wr_pwr) begin
            bias_output_enable_ff <= reg_wdata[mic_detect_pkg::BIAS_ENABLE_BIT];
        end
    end

    // Status bit positions are not stored, so writes there cannot disturb detection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bias_voltage_select_ff <= mic_detect_pkg::BIAS_LEVEL_RST;
            current_detect_enable_ff <= mic_detect_pkg::DETECT_ENABLE_RST;
            accessory_threshold_sel_ff <= mic_detect_pkg::ACC_THR_RST;
            short_threshold_sel_ff <= mic_detect_pkg::SHORT_THR_RST;
        end else if (wr_det) begin
            bias_voltage_select_ff <= reg_wdata[mic_detect_pkg::BIAS_LEVEL_BIT];
            current_detect_enable_ff <= reg_wdata[mic_detect_pkg::DETECT_ENABLE_BIT];
            accessory_threshold_sel_ff <= reg_wdata[mic_detect_pkg::ACC_THR_MSB:
                mic_detect_pkg::ACC_THR_LSB];
            short_threshold_sel_ff <= reg_wdata[mic_detect_pkg::SHORT_THR_MSB:
                mic_detect_pkg::SHORT_THR_LSB];
        end
    end

    // Register read-back, answered one cycle after the strobe
    always_comb begin
        nxt_rdata = 16'h0000;
        case (reg_addr)
            mic_detect_pkg::PWR_MGMT_ONE_ADDR: begin
                nxt_rdata[mic_detect_pkg::BIAS_ENABLE_BIT] = bias_output_enable_ff;
            end
            mic_detect_pkg::BIAS_DETECT_ADDR: begin
                nxt_rdata[mic_detect_pkg::BIAS_LEVEL_BIT] = bias_voltage_select_ff;
                nxt_rdata[mic_detect_pkg::DETECT_ENABLE_BIT] = current_detect_enable_ff;
                nxt_rdata[mic_detect_pkg::ACC_THR_MSB:mic_detect_pkg::ACC_THR_LSB] =
                    accessory_threshold_sel_ff;
                nxt_rdata[mic_detect_pkg::SHORT_THR_MSB:mic_detect_pkg::SHORT_THR_LSB] =
                    short_threshold_sel_ff;
                nxt_rdata[mic_detect_pkg::ACC_STATUS_BIT] = accessory_over_flag_ff;
                nxt_rdata[mic_detect_pkg::SHORT_STATUS_BIT] = short_over_flag_ff;
            end
            default: begin
                nxt_rdata = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata_ff <= 16'h0000;
            reg_rvalid_ff <= 1'h0;
        end else begin
            reg_rdata_ff <= reg_rd ? nxt_rdata : reg_rdata_ff;
            reg_rvalid_ff <= reg_rd;
        end
    end

    // Live status: synchronised comparison, gated by the single detect enable
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            accessory_over_flag_ff <= mic_detect_pkg::STATUS_RST;
            short_over_flag_ff <= mic_detect_pkg::STATUS_RST;
        end else begin
            accessory_over_flag_ff <= current_detect_enable_ff && acc_sync;
            short_over_flag_ff <= current_detect_enable_ff && short_sync;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            accessory_gpio_ff <= 1'h0;
            short_gpio_ff <= 1'h0;
        end else begin
            accessory_gpio_ff <= accessory_over_flag_ff;
            short_gpio_ff <= short_over_flag_ff;
        end
    end

    // Measurement strobe; the filters only move while clocking criteria hold
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meas_cnt_ff <= '0;
            meas_tick_ff <= 1'h0;
        end else begin
            meas_cnt_ff <= (meas_cnt_ff == MEAS_LAST) ? '0 : meas_cnt_ff + MW'(1);
            meas_tick_ff <= meas_cnt_ff == MEAS_LAST;
        end
    end

    // A change during a clock stop is kept in the comparator level, so it is
    // taken at the first strobe after the criteria return (the tenth for the short filter)
    assign acc_if.tick = meas_tick_ff && clock_criteria_ok;
    assign acc_if.run = current_detect_enable_ff;
    assign acc_if.sample = acc_sync;
    assign short_if.tick = meas_tick_ff && clock_criteria_ok;
    assign short_if.run = current_detect_enable_ff;
    assign short_if.sample = short_sync;

    det_filter #(
        .COUNT(mic_detect_pkg::ACC_FILTER_COUNT)
    ) acc_filter_u (
        .sys_clk(sys_clk),
        .reset(reset),
        .port(acc_if.filter)
    );

    det_filter #(
        .COUNT(mic_detect_pkg::SHORT_FILTER_COUNT)
    ) short_filter_u (
        .sys_clk(sys_clk),
        .reset(reset),
        .port(short_if.filter)
    );

    // Event pulses to the interrupt controller; polarity picks rise or fall
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            accessory_event_ff <= 1'h0;
            short_event_ff <= 1'h0;
        end else begin
            accessory_event_ff <= acc_if.changed &&
                (acc_if.level != accessory_edge_polarity);
            short_event_ff <= short_if.changed &&
                (short_if.level != short_edge_polarity);
        end
    end

    // Input routing per side; selecting pin two or three also joins pin one
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pga_pin_connect_ff <= '0;
            boost_connect_ff <= '0;
            mixer_four_connect_ff <= 2'h0;
        end else begin
            for (int s = 0; s < 2; s++) begin
                pga_pin_connect_ff[s] <= 4'h0;
                if (pga_enable[s]) begin
                    case (mic_detect_pkg::pga_src_t'(pga_src_sel[s]))
                        mic_detect_pkg::SRC_PIN_ONE: pga_pin_connect_ff[s] <= 4'h1;
                        mic_detect_pkg::SRC_PIN_TWO: pga_pin_connect_ff[s] <= 4'h3;
                        mic_detect_pkg::SRC_PIN_THREE: pga_pin_connect_ff[s] <= 4'h5;
                        mic_detect_pkg::SRC_PIN_FOUR: pga_pin_connect_ff[s] <= 4'h8;
                        default: pga_pin_connect_ff[s] <= 4'h0;
                    endcase
                end
                boost_connect_ff[s] <= {boost_pin_three_sel[s], boost_pin_two_sel[s]};
                mixer_four_connect_ff[s] <= mixer_pin_four_sel[s];
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_det_write;
        wr_det ##1 1'b1;
    endsequence

    a_pga_exclusive: assert property (
        $countones(pga_pin_connect_ff[0][3:1]) <= 1 &&
        $countones(pga_pin_connect_ff[1][3:1]) <= 1)
        else $error("more than one source on a gain amplifier");

    a_pin_one_auto: assert property (
        (pga_enable[1] && pga_src_sel[1] inside {2'h1, 2'h2})
            |=> pga_pin_connect_ff[1][0] && !pga_pin_connect_ff[1][3])
        else $error("pin one not joined for pin two or three");

    a_boost_bypass: assert property (
        boost_pin_two_sel[0] |=> boost_connect_ff[0][0] && (pga_pin_connect_ff[0][1] == 1'b0
            || $past(pga_enable[0])))
        else $error("boost bypass route missing");

    a_mixer_four: assert property (
        mixer_pin_four_sel[1] != mixer_four_connect_ff[1] |=> $changed(mixer_four_connect_ff[1]))
        else $error("pin four mixer route not followed");

    a_bias_enable: assert property (
        wr_pwr |=> bias_output_enable_ff == $past(reg_wdata[mic_detect_pkg::BIAS_ENABLE_BIT]))
        else $error("bias enable not written");

    a_bias_level: assert property (
        s_det_write |-> bias_voltage_select_ff == $past(reg_wdata[mic_detect_pkg::BIAS_LEVEL_BIT]))
        else $error("bias level not written");

    a_detect_off: assert property (
        (!current_detect_enable_ff)[*2] |-> !accessory_over_flag_ff && !short_over_flag_ff
            && !acc_if.level && !short_if.level)
        else $error("detection active while disabled");

    a_thresholds: assert property (
        s_det_write |-> {accessory_threshold_sel_ff, short_threshold_sel_ff} ==
            $past(reg_wdata[mic_detect_pkg::ACC_THR_MSB:mic_detect_pkg::SHORT_THR_LSB]))
        else $error("threshold fields not written");

    a_status_live: assert property (
        current_detect_enable_ff |=> accessory_over_flag_ff == $past(acc_sync)
            && short_over_flag_ff == $past(short_sync))
        else $error("status does not follow comparison");

    a_gpio_follow: assert property (
        ##1 accessory_gpio_ff == $past(accessory_over_flag_ff)
            && short_gpio_ff == $past(short_over_flag_ff))
        else $error("pin outputs do not follow status");

    a_event_edge: assert property (
        (acc_if.changed && acc_if.level != accessory_edge_polarity) |=> accessory_event_ff)
        else $error("accessory event missed");

    a_no_clock_hold: assert property (
        (!clock_criteria_ok && current_detect_enable_ff) |=> $stable(short_if.level)
            || !current_detect_enable_ff)
        else $error("filter moved while clock criteria unmet");

    a_status_ro: assert property (
        (wr_det && !current_detect_enable_ff) |=> !accessory_over_flag_ff && !short_over_flag_ff)
        else $error("status bits took a written value");
endmodule : mic_bias_detect_top

// File: mic_accessory_model.sv
// Behavioural electret accessory and bias current comparators.
// Assumes the bench sets the drawn current; no current flows while bias is off.
`timescale 1ns/1ns
module mic_accessory_model (
    input wire logic bias_on,
    input wire logic [2:0] acc_sel,
    input wire logic [1:0] short_sel,
    input wire logic [11:0] current_ua,
    output logic acc_cmp,
    output logic short_cmp
);
    localparam int ACC_UA [8] = '{64, 166, 375, 475, 575, 680, 885, 990};
    localparam int SHORT_UA [4] = '{515, 680, 1050, 1215};

    // Comparators keep running when detection is disabled, so gating is the design's job
    always_comb begin
        acc_cmp = bias_on && (int'(current_ua) > ACC_UA[acc_sel]);
        short_cmp = bias_on && (int'(current_ua) > SHORT_UA[short_sel]);
    end
endmodule : mic_accessory_model

// File: tb_mic_bias_and_current_detect.sv
// Self-checking bench for the bias control, routing and current detection.
// Assumes a short measurement period so the ten-sample filter runs quickly.
`timescale 1ns/1ns
module tb_mic_bias_and_current_detect;
    localparam int M = 8;
    localparam int CEIL = 12000;
    localparam logic [7:0] A19 = mic_detect_pkg::PWR_MGMT_ONE_ADDR;
    localparam logic [7:0] A30 = mic_detect_pkg::BIAS_DETECT_ADDR;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata_ff, rd;
    logic reg_rvalid_ff, acc_cmp, short_cmp;
    logic clock_criteria_ok = 1'b1;
    logic accessory_edge_polarity = 1'b0;
    logic short_edge_polarity = 1'b0;
    logic [1:0][1:0] pga_src_sel = '0;
    logic [1:0] pga_enable = 2'h0;
    logic [1:0] boost_pin_two_sel = 2'h0;
    logic [1:0] boost_pin_three_sel = 2'h0;
    logic [1:0] mixer_pin_four_sel = 2'h0;
    logic bias_output_enable_ff, bias_voltage_select_ff, current_detect_enable_ff;
    logic [2:0] accessory_threshold_sel_ff;
    logic [1:0] short_threshold_sel_ff;
    logic accessory_over_flag_ff, short_over_flag_ff, accessory_gpio_ff, short_gpio_ff;
    logic accessory_event_ff, short_event_ff;
    logic [1:0][3:0] pga_pin_connect_ff;
    logic [1:0][1:0] boost_connect_ff;
    logic [1:0] mixer_four_connect_ff;
    logic [11:0] cur_ua = 12'h000;
    int acc_ua [8] = '{64, 166, 375, 475, 575, 680, 885, 990};
    int short_ua [4] = '{515, 680, 1050, 1215};
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int acc_events = 0;
    int short_events = 0;

    mic_bias_detect_top #(.MEAS_CYCLES(M)) i_mic_bias_detect_top (
        .sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff), .acc_compare_in(acc_cmp),
        .short_compare_in(short_cmp), .clock_criteria_ok(clock_criteria_ok),
        .accessory_edge_polarity(accessory_edge_polarity),
        .short_edge_polarity(short_edge_polarity), .pga_src_sel(pga_src_sel),
        .pga_enable(pga_enable), .boost_pin_two_sel(boost_pin_two_sel),
        .boost_pin_three_sel(boost_pin_three_sel), .mixer_pin_four_sel(mixer_pin_four_sel),
        .bias_output_enable_ff(bias_output_enable_ff),
        .bias_voltage_select_ff(bias_voltage_select_ff),
        .current_detect_enable_ff(current_detect_enable_ff),
        .accessory_threshold_sel_ff(accessory_threshold_sel_ff),
        .short_threshold_sel_ff(short_threshold_sel_ff),
        .accessory_over_flag_ff(accessory_over_flag_ff),
        .short_over_flag_ff(short_over_flag_ff), .accessory_gpio_ff(accessory_gpio_ff),
        .short_gpio_ff(short_gpio_ff), .accessory_event_ff(accessory_event_ff),
        .short_event_ff(short_event_ff), .pga_pin_connect_ff(pga_pin_connect_ff),
        .boost_connect_ff(boost_connect_ff), .mixer_four_connect_ff(mixer_four_connect_ff)
    );

    mic_accessory_model i_mic_accessory_model (
        .bias_on(bias_output_enable_ff), .acc_sel(accessory_threshold_sel_ff),
        .short_sel(short_threshold_sel_ff), .current_ua(cur_ua),
        .acc_cmp(acc_cmp), .short_cmp(short_cmp)
    );

    always #4 sys_clk = ~sys_clk;

    task wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // Event pulses last one cycle, so they are counted at every edge
    always @(posedge sys_clk) begin
        cycles++;
        if (accessory_event_ff === 1'b1) acc_events++;
        if (short_event_ff === 1'b1) short_events++;
        if (cycles == CEIL) begin
            fails++;
            wrap_up;
        end
    end

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task reg_write(input logic [7:0] addr, input logic [15:0] data);
        reg_wr = 1'b1;
        reg_addr = addr;
        reg_wdata = data;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : reg_write

    task reg_read(input logic [7:0] addr, output logic [15:0] data);
        reg_rd = 1'b1;
        reg_addr = addr;
        tick(1);
        reg_rd = 1'b0;
        data = reg_rdata_ff;
        check(16'(reg_rvalid_ff), 16'h0001);
        tick(1);
        check(16'(reg_rvalid_ff), 16'h0000);
    endtask : reg_read

    task reset_values;
        check(16'(bias_output_enable_ff), 16'h0000);
        check(16'(bias_voltage_select_ff), 16'h0001);
        check(16'(current_detect_enable_ff), 16'h0000);
        check(16'({accessory_threshold_sel_ff, short_threshold_sel_ff}), 16'h0000);
        check(16'({accessory_over_flag_ff, short_over_flag_ff}), 16'h0000);
        reg_read(A30, rd);
        check(rd, 16'h0001);
        reg_read(A19, rd);
        check(rd, 16'h0000);
    endtask : reset_values

    task register_access;
        reg_write(A19, 16'hFFFF);
        check(16'(bias_output_enable_ff), 16'h0001);
        reg_read(A19, rd);
        check(rd, 16'h0002);
        reg_write(A30, 16'hFFFE);
        check(16'(bias_voltage_select_ff), 16'h0000);
        check(16'({accessory_threshold_sel_ff, short_threshold_sel_ff}), 16'h001F);
        reg_read(A30, rd);
        check(rd, 16'h7E00);
        reg_write(8'h31, 16'hFFFF);
        reg_read(8'h31, rd);
        check(rd, 16'h0000);
        reg_write(A30, 16'h0201);
        check(16'(bias_voltage_select_ff), 16'h0001);
    endtask : register_access

    task routing;
        logic [3:0] conn [4];
        conn = '{4'h1, 4'h3, 4'h5, 4'h8};
        pga_enable = 2'h3;
        for (int s = 0; s < 4; s++) begin
            pga_src_sel = {2'(s), 2'(s)};
            tick(2);
            check(16'(pga_pin_connect_ff), 16'({conn[s], conn[s]}));
        end
        pga_src_sel = {2'h2, 2'h1};
        pga_enable = 2'h1;
        boost_pin_two_sel = 2'h1;
        boost_pin_three_sel = 2'h2;
        mixer_pin_four_sel = 2'h2;
        tick(2);
        check(16'(pga_pin_connect_ff), 16'h0003);
        check(16'(boost_connect_ff), 16'h0009);
        check(16'(mixer_four_connect_ff), 16'h0002);
    endtask : routing

    task threshold_sweep;
        for (int k = 0; k < 8; k++) begin
            reg_write(A30, 16'h0201 | (16'(k) << 12));
            cur_ua = 12'(acc_ua[k] + 1);
            tick(8);
            check(16'(accessory_over_flag_ff), 16'h0001);
            cur_ua = 12'(acc_ua[k] - 1);
            tick(8);
            check(16'(accessory_over_flag_ff), 16'h0000);
        end
        for (int k = 0; k < 4; k++) begin
            reg_write(A30, 16'h0201 | (16'(k) << 10));
            cur_ua = 12'(short_ua[k] + 1);
            tick(8);
            check(16'(short_over_flag_ff), 16'h0001);
            cur_ua = 12'(short_ua[k] - 1);
            tick(8);
            check(16'(short_over_flag_ff), 16'h0000);
        end
    endtask : threshold_sweep

    task status_and_gpio;
        reg_write(A30, 16'h02C1);
        cur_ua = 12'd600;
        tick(8);
        reg_read(A30, rd);
        check(rd, 16'h02C1);
        check(16'({accessory_gpio_ff, short_gpio_ff}), 16'h0003);
        cur_ua = 12'd100;
        tick(8);
        reg_read(A30, rd);
        check(rd, 16'h0281);
        check(16'({accessory_gpio_ff, short_gpio_ff}), 16'h0002);
    endtask : status_and_gpio

    task detect_disabled;
        reg_write(A30, 16'h0001);
        cur_ua = 12'd1300;
        acc_events = 0;
        short_events = 0;
        tick(12 * M);
        check(16'({accessory_over_flag_ff, short_over_flag_ff}), 16'h0000);
        check(16'(acc_events + short_events), 16'h0000);
        reg_write(A30, 16'h0201);
        tick(8);
        check(16'({accessory_over_flag_ff, short_over_flag_ff}), 16'h0003);
        cur_ua = 12'd0;
        tick(14 * M);
    endtask : detect_disabled

    task acc_event(input logic pol, input logic [11:0] level, input int exp);
        accessory_edge_polarity = pol;
        acc_events = 0;
        cur_ua = level;
        tick(4 * M);
        check(16'(acc_events), 16'(exp));
    endtask : acc_event

    task short_filter;
        int n, na, ns;
        short_edge_polarity = 1'b0;
        accessory_edge_polarity = 1'b0;
        short_events = 0;
        cur_ua = 12'd1300;
        tick(5 * M);
        cur_ua = 12'd0;
        tick(12 * M);
        check(16'(short_events), 16'h0000);
        acc_events = 0;
        n = 0;
        na = 0;
        ns = 0;
        cur_ua = 12'd1300;
        while ((na == 0 || ns == 0) && n < 15 * M) begin
            tick(1);
            n++;
            if (acc_events != 0 && na == 0) na = n;
            if (short_events != 0 && ns == 0) ns = n;
        end
        // Both filters share the strobe, so the gap is nine measurement periods
        check(16'(ns - na >= 9 * M - 1 && ns - na <= 9 * M + 1), 16'h0001);
        check(16'(short_gpio_ff), 16'h0001);
        // Release with polarity 1 must give exactly one short event
        short_edge_polarity = 1'b1;
        short_events = 0;
        cur_ua = 12'd0;
        tick(14 * M);
        check(16'(short_events), 16'h0001);
    endtask : short_filter

    task clock_gate;
        clock_criteria_ok = 1'b0;
        acc_events = 0;
        cur_ua = 12'd200;
        tick(20 * M);
        check(16'(acc_events), 16'h0000);
        check(16'(accessory_over_flag_ff), 16'h0001);
        clock_criteria_ok = 1'b1;
        tick(3 * M);
        check(16'(acc_events), 16'h0001);
    endtask : clock_gate

    initial begin
        tick(2);
        reset = 1'b0;
        tick(1);
        reset_values;
        register_access;
        routing;
        threshold_sweep;
        status_and_gpio;
        detect_disabled;
        acc_event(1'b0, 12'd200, 1);
        acc_event(1'b0, 12'd0, 0);
        acc_event(1'b1, 12'd200, 0);
        acc_event(1'b1, 12'd0, 1);
        short_filter;
        clock_gate;
        wrap_up;
    end
endmodule : tb_mic_bias_and_current_detect
